// ===== bench/sarrd_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_asserts #(
  parameter int CONV_CYC = 297
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic convert_strobe,
  input wire logic link_sck,
  input wire logic read_enable_or_serial_in,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line,
  input wire logic busy
);
  // counted, since a repetition this long would not unroll
  int unsigned busy_cnt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      busy_cnt <= 0;
    else
      busy_cnt <= busy ? busy_cnt + 1 : 0;
  end
  a_strobe_starts_conv: assert property ($rose(convert_strobe) && !busy |-> ##[2:5] busy)
    else $error("busy did not follow strobe");
  a_busy_length: assert property ($fell(busy) |-> busy_cnt == CONV_CYC)
    else $error("busy length wrong");
  a_strobe_hold: assert property ($rose(convert_strobe) |-> convert_strobe[*3] ##1 !convert_strobe)
    else $error("strobe width wrong");
  a_oe_on: assert property ($fell(read_enable_or_serial_in) |-> ##[2:4] sdo_oe)
    else $error("output not enabled");
  a_oe_off: assert property ($rose(read_enable_or_serial_in) |-> ##[2:4] !sdo_oe)
    else $error("output not released");
  a_sdo_quiet: assert property ((!busy && !link_sck)[*6] |-> $stable(sdo))
    else $error("output moved without shift clock");
  a_sck_idle_busy: assert property (busy |-> !link_sck)
    else $error("shift clock during conversion");
  a_sck_while_read: assert property (link_sck |-> !read_enable_or_serial_in)
    else $error("shift clock with output disabled");
  a_read_between: assert property ($fell(read_enable_or_serial_in) |-> !busy)
    else $error("read started during conversion");
  a_sck_half_period: assert property ($rose(link_sck) |-> link_sck[*2] ##1 !link_sck)
    else $error("shift clock high time wrong");
endmodule // sarrd_asserts
`default_nettype wire

// ===== bench/sarrd_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_tb;
  localparam int unsigned CONV = 40;
  localparam int unsigned ACQ  = 20;
  logic        i_ref_clk  = 1'b0;
  logic        i_resetn   = 1'b0;
  logic        supply_low = 1'b0;
  logic        chain_b    = 1'b0;
  logic        start      = 1'b0;
  logic [19:0] sample_a   = 20'h0;
  logic [19:0] sample_b   = 20'h0;
  logic        ready, done, pdown, acq, inval, init_ok, inval_b;
  logic        pdown_b, acq_b, init_b;
  logic [19:0] data;
  int          failures   = 0;
  int          cmp_count  = 0;
  sarrd_if lnk ();
  sarrd_if lnk_b ();
  always #5 i_ref_clk = ~i_ref_clk;
  sarrd_device #(.INIT_CYC(50), .CONV_CYC(CONV), .ACQ_CYC(ACQ)) sarrd_device_i (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_supply_low(supply_low),
    .i_chain_mode(1'b0), .i_sample(sample_a), .link(lnk), .o_powered_down(pdown),
    .o_acq_active(acq), .o_result_invalid(inval), .o_init_done(init_ok));
  // second device driven by the bench itself, for chain mode and misuse
  sarrd_device #(.INIT_CYC(50), .CONV_CYC(CONV), .ACQ_CYC(ACQ)) sarrd_device_i2 (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_supply_low(supply_low),
    .i_chain_mode(chain_b), .i_sample(sample_b), .link(lnk_b), .o_powered_down(pdown_b),
    .o_acq_active(acq_b), .o_result_invalid(inval_b), .o_init_done(init_b));
  sarrd_host #(.INIT_CYC(50)) sarrd_host_i (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_start(start), .link(lnk),
    .o_ready(ready), .o_done(done), .o_data(data));
  sarrd_asserts #(.CONV_CYC(CONV)) sarrd_asserts_i (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .convert_strobe(lnk.convert_strobe),
    .link_sck(lnk.link_sck), .read_enable_or_serial_in(lnk.read_enable_or_serial_in),
    .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .sdo_line(lnk.sdo_line), .busy(lnk.busy));

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic test_reset;
    int n;
    n = 0;
    chk("busy", 20'h0, 20'(lnk.busy));
    chk("powered down", 20'h1, 20'(pdown));
    chk("oe idle", 20'h0, 20'(lnk.sdo_oe));
    repeat (5) @(negedge i_ref_clk);
    lnk_b.convert_strobe = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    lnk_b.convert_strobe = 1'b0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("ready", 20'h1, 20'(ready));
    repeat (3) @(negedge i_ref_clk);
    chk("early flag", 20'h1, 20'(inval_b));
    chk("init wait", 20'h1, 20'(n >= 40));
    chk("init done", 20'h1, 20'(init_ok));
    chk("init done b", 20'h1, 20'(init_b));
    chk("down again b", 20'h1, 20'(pdown_b));
    $display("test_reset done");
  endtask

  task automatic test_read(input logic [19:0] v);
    int n;
    int bsy;
    int acqn;
    n = 0;
    bsy = 0;
    acqn = 0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("ready", 20'h1, 20'(ready));
    sample_a = v;
    start = 1'b1;
    @(negedge i_ref_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000)
    begin
      @(negedge i_ref_clk);
      n++;
      bsy += (lnk.busy === 1'b1 && pdown === 1'b0);
      acqn += (lnk.busy === 1'b1 && acq === 1'b1);
    end
    chk("done", 20'h1, 20'(done));
    chk("result", v, data);
    chk("awake while busy", 20'(CONV), 20'(bsy));
    chk("acquire start", 20'(CONV - ACQ), 20'(acqn));
    chk("power down after", 20'h1, 20'(pdown));
    chk("acquiring", 20'h1, 20'(acq));
    chk("valid flag", 20'h0, 20'(inval));
    $display("test_read %h done", v);
  endtask

  task automatic test_supply;
    int n;
    n = 0;
    supply_low = 1'b1;
    repeat (5) @(negedge i_ref_clk);
    chk("reinit clears", 20'h0, 20'(init_ok));
    chk("reinit clears b", 20'h0, 20'(init_b));
    supply_low = 1'b0;
    while (init_ok !== 1'b1 && n < 200)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("reinit wait", 20'h1, 20'(n >= 45 && n <= 60));
    chk("reinit b", 20'h1, 20'(init_b));
    $display("test_supply done");
  endtask

  task automatic test_chain;
    logic [19:0] b;
    int n;
    b = 20'h3c96a;
    n = 0;
    chain_b = 1'b1;
    sample_b = 20'hc3a51;
    repeat (5) @(negedge i_ref_clk);
    chk("chain oe", 20'h1, 20'(lnk_b.sdo_oe));
    // second strobe lands well past the start window and must be ignored
    for (int i = 0; i < 120; i++)
    begin
      lnk_b.convert_strobe = (i < 3) || (i >= 13 && i < 16);
      @(negedge i_ref_clk);
      n += (lnk_b.busy === 1'b1);
    end
    chk("no restart", 20'(CONV), 20'(n));
    chk("valid flag b", 20'h0, 20'(inval_b));
    chk("down after b", 20'h1, 20'(pdown_b));
    chk("acquiring b", 20'h1, 20'(acq_b));
    chk("chain msb", 20'(sample_b[19]), 20'(lnk_b.sdo));
    #7;
    for (int k = 1; k < 40; k++)
    begin
      lnk_b.read_enable_or_serial_in = (k <= 20) ? b[20-k] : 1'b0;
      #20 lnk_b.link_sck = 1'b1;
      #40 lnk_b.link_sck = 1'b0;
      #20;
      chk("chain bit", 20'(k < 20 ? sample_b[19-k] : b[39-k]), 20'(lnk_b.sdo));
    end
    // normal mode with the output enabled through a whole conversion
    @(negedge i_ref_clk);
    chain_b = 1'b0;
    lnk_b.read_enable_or_serial_in = 1'b0;
    sample_b = 20'ha5c3e;
    repeat (4) @(negedge i_ref_clk);
    lnk_b.convert_strobe = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    lnk_b.convert_strobe = 1'b0;
    repeat (CONV + 6) @(negedge i_ref_clk);
    chk("normal oe on", 20'h1, 20'(lnk_b.sdo_oe));
    chk("msb at busy fall", 20'(sample_b[19]), 20'(lnk_b.sdo_line));
    lnk_b.read_enable_or_serial_in = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    chk("normal oe off", 20'h0, 20'(lnk_b.sdo_oe));
    chk("line released", 20'h0, 20'(lnk_b.sdo_line));
    $display("test_chain done");
  endtask

  initial
  begin
    lnk_b.convert_strobe = 1'b0;
    lnk_b.link_sck = 1'b0;
    lnk_b.read_enable_or_serial_in = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    test_reset;
    test_read(20'h80001);
    test_read(20'h7fffe);
    test_supply;
    test_read(20'h5a5a5);
    test_chain;
    test_done;
  end

  initial
  begin
    #100000;
    failures++;
    $display("BAD watchdog expected finish seen hang");
    test_done;
  end
endmodule // sarrd_tb
`default_nettype wire

// ===== hdl/sarrd_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "sarrd_params.svh"
module sarrd_device #(
  parameter int unsigned RES_BITS = `SARRD_RES_BITS,
  parameter int unsigned INIT_CYC = `SARRD_INIT_CYC,
  parameter int unsigned CONV_CYC = `SARRD_CONV_CYC,
  parameter int unsigned ACQ_CYC  = `SARRD_ACQ_START_CYC
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_supply_low,
  input  wire logic                i_chain_mode,
  input  wire logic [RES_BITS-1:0] i_sample,
  sarrd_if.device                  link,
  output logic                     o_powered_down,
  output logic                     o_acq_active,
  output logic                     o_result_invalid,
  output logic                     o_init_done
);
  logic [3:0]                  pin_sync;
  logic                        strobe_s;
  logic                        brown_s;
  logic                        chain_s;
  logic                        rden_s;
  logic                        strobe_d_reg;
  logic                        strobe_rise;
  logic [31:0]                 init_cnt_reg;
  logic                        init_done_reg;
  sarrd_pkg::sarrd_dev_state_t state_reg;
  logic [31:0]                 tmr_reg;
  logic [RES_BITS-1:0]         hold_reg;
  logic [RES_BITS-1:0]         result_reg;
  logic                        busy_reg;
  logic                        pdown_reg;
  logic                        acq_reg;
  logic                        invalid_reg;
  logic                        invalid_next;
  logic                        oe_reg;
  logic                        conv_end;
  logic                        link_clr_n;
  logic [RES_BITS-1:0]         shift_reg;
  logic                        loaded_reg;

  sarrd_sync #(
    .WIDTH (4)
  ) sarrd_sync_i (
    .i_clk    (i_ref_clk),
    .i_resetn (i_resetn),
    .i_async  ({link.convert_strobe, i_supply_low, i_chain_mode,
                link.read_enable_or_serial_in}),
    .o_sync   (pin_sync)
  );

  assign strobe_s = pin_sync[3];
  assign brown_s  = pin_sync[2];
  assign chain_s  = pin_sync[1];
  assign rden_s   = pin_sync[0];

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      strobe_d_reg <= 1'b0;
    else
      strobe_d_reg <= strobe_s;
  end

  assign strobe_rise = strobe_s & ~strobe_d_reg;
  assign conv_end = (state_reg == sarrd_pkg::DEV_CONV) && (tmr_reg == CONV_CYC - 1);
  // a start before the settling period ends is accepted but flagged
  assign invalid_next = ~init_done_reg;

  // reinitialisation period, restarted after every brown-out
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      init_cnt_reg  <= '0;
      init_done_reg <= 1'b0;
    end
    else if (brown_s)
    begin
      init_cnt_reg  <= '0;
      init_done_reg <= 1'b0;
    end
    else if (!init_done_reg)
    begin
      if (init_cnt_reg == INIT_CYC - 1)
        init_done_reg <= 1'b1;
      else
        init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
    end
  end

  // conversion sequencer
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= sarrd_pkg::DEV_PDOWN;
      tmr_reg   <= '0;
    end
    else if (brown_s)
    begin
      state_reg <= sarrd_pkg::DEV_PDOWN;
      tmr_reg   <= '0;
    end
    else
    begin
      unique case (state_reg)
        sarrd_pkg::DEV_PDOWN:
        begin
          if (strobe_rise)
          begin
            state_reg <= sarrd_pkg::DEV_CONV;
            tmr_reg   <= '0;
          end
        end
        sarrd_pkg::DEV_CONV:
        begin
          // strobe edges here are ignored
          if (conv_end)
            state_reg <= sarrd_pkg::DEV_PDOWN;
          else
            tmr_reg <= tmr_reg + 32'h0000_0001;
        end
      endcase
    end
  end

  // sample and result words
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hold_reg    <= '0;
      result_reg  <= '0;
      invalid_reg <= 1'b0;
    end
    else if (brown_s)
    begin
      hold_reg    <= '0;
      result_reg  <= '0;
      invalid_reg <= 1'b0;
    end
    else if (state_reg == sarrd_pkg::DEV_PDOWN && strobe_rise)
    begin
      hold_reg    <= i_sample;
      invalid_reg <= invalid_next;
    end
    else if (conv_end)
      result_reg <= hold_reg; // no cycle latency: result of this conversion
  end

  // busy, power-down and acquisition indicators
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      busy_reg  <= 1'b0;
      pdown_reg <= 1'b1;
      acq_reg   <= 1'b0;
    end
    else if (brown_s)
    begin
      busy_reg  <= 1'b0;
      pdown_reg <= 1'b1;
      acq_reg   <= 1'b0;
    end
    else if (state_reg == sarrd_pkg::DEV_PDOWN && strobe_rise)
    begin
      busy_reg  <= 1'b1;
      pdown_reg <= 1'b0;
      acq_reg   <= 1'b0;
    end
    else if (conv_end)
    begin
      busy_reg  <= 1'b0;
      pdown_reg <= 1'b1;
    end
    else if (state_reg == sarrd_pkg::DEV_CONV && tmr_reg == ACQ_CYC - 1)
      acq_reg <= 1'b1;
  end

  // output enable follows the synchronised select pins, three cycles after the pins
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      oe_reg <= 1'b0;
    else
      oe_reg <= chain_s | ~rden_s;
  end

  // the shift path is held clear while busy, so the result word is
  // stable whenever the link clock may sample it; reads that overlap
  // a conversion see only the msb of the previous result
  assign link_clr_n = i_resetn & ~busy_reg;

  always_ff @(posedge link.link_sck or negedge link_clr_n)
  begin
    if (!link_clr_n)
    begin
      shift_reg  <= '0;
      loaded_reg <= 1'b0;
    end
    else
    begin
      loaded_reg <= 1'b1;
      if (loaded_reg)
        shift_reg <= {shift_reg[RES_BITS-2:0], link.read_enable_or_serial_in};
      else
        shift_reg <= {result_reg[RES_BITS-2:0], link.read_enable_or_serial_in};
    end
  end

  // before the first rise the msb comes straight from the result word
  assign link.sdo    = loaded_reg ? shift_reg[RES_BITS-1] : result_reg[RES_BITS-1];
  assign link.sdo_oe = oe_reg;
  assign link.busy   = busy_reg;

  assign o_powered_down   = pdown_reg;
  assign o_acq_active     = acq_reg;
  assign o_result_invalid = invalid_reg;
  assign o_init_done      = init_done_reg;
endmodule // sarrd_device
`default_nettype wire

// ===== hdl/sarrd_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "sarrd_params.svh"
module sarrd_host #(
  parameter int unsigned RES_BITS    = `SARRD_RES_BITS,
  parameter int unsigned CHAIN_LEN   = 1,
  parameter int unsigned INIT_CYC    = `SARRD_INIT_CYC,
  parameter int unsigned SCK_HALF    = `SARRD_SCK_HALF,
  parameter int unsigned STROBE_HOLD = `SARRD_STROBE_HOLD_CYC,
  parameter int unsigned RDEN_SETUP  = `SARRD_RDEN_SETUP
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_start,
  sarrd_if.host                              link,
  output logic                               o_ready,
  output logic                               o_done,
  output logic [RES_BITS*CHAIN_LEN-1:0]      o_data
);
  localparam int unsigned TOTAL = RES_BITS * CHAIN_LEN;

  sarrd_pkg::sarrd_hst_state_t state_reg;
  logic [1:0]                  in_sync;
  logic                        busy_s;
  logic                        sdo_s;
  logic [31:0]                 cnt_reg;
  logic [31:0]                 bits_reg;
  logic                        sck_reg;
  logic                        strobe_reg;
  logic                        rden_reg;
  logic                        ready_reg;
  logic                        done_reg;
  logic [TOTAL-1:0]            shift_reg;
  logic [TOTAL-1:0]            data_reg;

  sarrd_sync #(
    .WIDTH (2)
  ) sarrd_sync_i (
    .i_clk    (i_ref_clk),
    .i_resetn (i_resetn),
    .i_async  ({link.busy, link.sdo_line}),
    .o_sync   (in_sync)
  );

  assign busy_s = in_sync[1];
  assign sdo_s  = in_sync[0];

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= sarrd_pkg::HST_INIT;
      cnt_reg   <= '0;
      bits_reg  <= '0;
      sck_reg   <= 1'b0;
      strobe_reg <= 1'b0;
      rden_reg   <= 1'b1;
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
      shift_reg <= '0;
      data_reg  <= '0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        sarrd_pkg::HST_INIT:
        begin
          if (cnt_reg == INIT_CYC - 1)
          begin
            state_reg <= sarrd_pkg::HST_IDLE;
            ready_reg <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        sarrd_pkg::HST_IDLE:
        begin
          // shift clock stopped and output disabled while idle
          sck_reg <= 1'b0;
          rden_reg <= 1'b1;
          if (i_start)
          begin
            state_reg <= sarrd_pkg::HST_STROBE;
            ready_reg <= 1'b0;
            strobe_reg <= 1'b1;
            cnt_reg   <= '0;
          end
        end
        sarrd_pkg::HST_STROBE:
        begin
          // strobe falls well inside the start window
          if (cnt_reg == STROBE_HOLD - 1)
          begin
            strobe_reg <= 1'b0;
            state_reg <= sarrd_pkg::HST_WAIT_HI;
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        sarrd_pkg::HST_WAIT_HI:
        begin
          if (busy_s)
            state_reg <= sarrd_pkg::HST_WAIT_LO;
        end
        sarrd_pkg::HST_WAIT_LO:
        begin
          // read after the conversion for best results
          if (!busy_s)
          begin
            rden_reg  <= 1'b0;
            cnt_reg   <= '0;
            bits_reg  <= '0;
            state_reg <= sarrd_pkg::HST_SETUP;
          end
        end
        sarrd_pkg::HST_SETUP:
        begin
          if (cnt_reg == RDEN_SETUP - 1)
          begin
            cnt_reg   <= '0;
            state_reg <= sarrd_pkg::HST_SHIFT;
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        sarrd_pkg::HST_SHIFT:
        begin
          if (cnt_reg == SCK_HALF - 1)
          begin
            cnt_reg <= '0;
            if (!sck_reg)
            begin
              // synchronised line is sampled at the next rising edge
              sck_reg   <= 1'b1;
              shift_reg <= {shift_reg[TOTAL-2:0], sdo_s};
              bits_reg  <= bits_reg + 32'h0000_0001;
            end
            else
            begin
              sck_reg <= 1'b0;
              if (bits_reg == TOTAL)
              begin
                rden_reg  <= 1'b1;
                data_reg  <= shift_reg;
                done_reg  <= 1'b1;
                ready_reg <= 1'b1;
                state_reg <= sarrd_pkg::HST_IDLE;
              end
            end
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        // an unused state code falls back to the settling wait
        default:
          state_reg <= sarrd_pkg::HST_INIT;
      endcase
    end
  end

  assign link.convert_strobe           = strobe_reg;
  assign link.link_sck                 = sck_reg;
  assign link.read_enable_or_serial_in = rden_reg;

  assign o_ready = ready_reg;
  assign o_done  = done_reg;
  assign o_data  = data_reg;
endmodule // sarrd_host
`default_nettype wire

// ===== hdl/sarrd_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sarrd_if;
  logic convert_strobe;
  logic link_sck;
  logic read_enable_or_serial_in;
  logic sdo;
  logic sdo_oe;
  logic busy;
  logic sdo_line;
  // undriven line reads low, as with a weak pull-down
  assign sdo_line = sdo_oe & sdo;
  modport device (
    input  convert_strobe,
    input  link_sck,
    input  read_enable_or_serial_in,
    output sdo,
    output sdo_oe,
    output busy
  );
  modport host (
    output convert_strobe,
    output link_sck,
    output read_enable_or_serial_in,
    input  sdo_line,
    input  busy
  );
endinterface
`default_nettype wire

// ===== hdl/sarrd_params.svh
// Notes on behaviour
// - host waits 200us after reinitialisation; the host waits only after reset, not after a brown-out
// - supply below 1V reinitialises device
// - convert strobe rise starts conversion, wakes
// - strobes during conversion are ignored
// - busy high throughout each conversion
// - host strobe edges within 40ns only
// - acquisition begins 675ns after start
// - conversion finishes within 3us
// - auto power-down, readout still allowed
// - host idles output and shift clock
// - device shifts on rise, host samples later
// - msb valid until first shift rise
// - host shift clock at least 20MHz
// - normal mode: read-enable high tri-states output
// - normal mode: msb shown when busy falls
// - shared line: one read-enable low only
// - chain mode: output always driven, serial in
// - chain: upstream msb after 20 clocks
`ifndef SARRD_PARAMS_SVH
`define SARRD_PARAMS_SVH
`define SARRD_RES_BITS 20
`define SARRD_REF_PERIOD_NS 10
`define SARRD_SYNC_LAT 3
`define SARRD_INIT_US 200
`define SARRD_INIT_CYC ((`SARRD_INIT_US * 1000 + `SARRD_REF_PERIOD_NS - 1) / `SARRD_REF_PERIOD_NS)
`define SARRD_CONV_MAX_NS 3000
`define SARRD_CONV_CYC (`SARRD_CONV_MAX_NS / `SARRD_REF_PERIOD_NS - `SARRD_SYNC_LAT)
`define SARRD_ACQ_START_NS 675
`define SARRD_ACQ_START_CYC ((`SARRD_ACQ_START_NS + `SARRD_REF_PERIOD_NS - 1) / `SARRD_REF_PERIOD_NS - `SARRD_SYNC_LAT)
`define SARRD_ACQ_TIME_NS 3312
`define SARRD_STROBE_WIN_NS 40
`define SARRD_STROBE_HOLD_CYC (`SARRD_STROBE_WIN_NS / `SARRD_REF_PERIOD_NS - 1)
`define SARRD_SCK_HALF 2
`define SARRD_RDEN_SETUP 4
`endif

// ===== hdl/sarrd_pkg.sv
`default_nettype none
package sarrd_pkg;
  typedef enum logic [0:0] {DEV_PDOWN, DEV_CONV} sarrd_dev_state_t;
  typedef enum logic [2:0] {
    HST_INIT,
    HST_IDLE,
    HST_STROBE,
    HST_WAIT_HI,
    HST_WAIT_LO,
    HST_SETUP,
    HST_SHIFT
  } sarrd_hst_state_t;
endpackage
`default_nettype wire

// ===== hdl/sarrd_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // meta_reg feeds sync_reg only
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule // sarrd_sync
`default_nettype wire
